// ==== config_host.sv ====
// Behavioural model of the external configuration host
`timescale 1ns/1ns
module config_host (
  input wire logic clk,
  input wire logic status_wire,
  output logic config_clock,
  output logic config_req_n,
  output logic [31:0] config_data,
  output logic user_startup_clock
);
  int cyc = 0;
  initial begin
    config_clock = 1'b0;
    config_req_n = 1'b1;
    config_data = 32'h0;
    user_startup_clock = 1'b0;
  end
  // Board oscillator, 300 ns period, well under the limit
  always #150 user_startup_clock = ~user_startup_clock;
  task automatic reconfig();
    int n;
    @(posedge clk);
    config_req_n <= 1'b0;
    repeat (25) @(posedge clk);
    config_req_n <= 1'b1;
    n = 0;
    while (status_wire !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    repeat (25) @(posedge clk);
    cyc = 0;
  endtask : reconfig
  // r clocks per word; the offset keeps clock phase apart from the system clock
  task automatic run(input int n, input int r);
    #37;
    repeat (n) begin
      if (cyc == r) #2000;
      // Inverse pattern on the clocks after the first of each word
      config_data = (cyc % r == 0) ? 32'hA5C3_0000 + 32'(cyc / r) : ~config_data;
      #400 config_clock = 1'b1;
      #400 config_clock = 1'b0;
      cyc++;
    end
  endtask : run
endmodule : config_host

// ==== passive_config_pkg.sv ====
// Constants, register map and state types of the passive configuration port
package passive_config_pkg;

  localparam int CLK_NS = 100;

  // Timing figures in their own unit, then derived cycle counts (least times round up)
  localparam int T_STATUS_MIN_NS = 268000;
  localparam int T_CD2UM_MIN_NS = 175000;
  localparam int T_POR_FAST_MIN_NS = 4000000;
  localparam int T_POR_STD_MIN_NS = 100000000;
  localparam int CFG_CLK_MAX_MHZ = 125;
  localparam int CFG_CLK_MIN_PERIOD_NS = (1000 + CFG_CLK_MAX_MHZ - 1) / CFG_CLK_MAX_MHZ;
  localparam int CD2CU_PERIODS = 4;
  localparam int T_CD2CU_NS = CD2CU_PERIODS * CFG_CLK_MIN_PERIOD_NS;
  localparam int USER_INIT_CLKS = 8576;

  localparam int STATUS_MIN_CYC = (T_STATUS_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_INIT_CYC = (T_CD2UM_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int POR_FAST_CYC = (T_POR_FAST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int POR_STD_CYC = (T_POR_STD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CD2CU_CYC = (T_CD2CU_NS + CLK_NS - 1) / CLK_NS;

  // Clock-to-word ratio minus one for 32-bit loading
  localparam logic [2:0] RM1_PLAIN = 3'h0;
  localparam logic [2:0] RM1_SECURE = 3'h3;
  localparam logic [2:0] RM1_DECOMP = 3'h7;

  // Load width codes
  localparam logic [1:0] W_SERIAL = 2'h0;
  localparam logic [1:0] W_X8 = 2'h1;
  localparam logic [1:0] W_X16 = 2'h2;
  localparam logic [1:0] W_X32 = 2'h3;

  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LENGTH = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_WORDS = 8'h0C;
  localparam logic [7:0] A_LAST = 8'h10;

  localparam logic [31:0] LENGTH_RST = 32'h0000_0020;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HSIZE_WORD = 2'h2;

  typedef struct packed {
    logic init_done_en;
    logic user_clk_en;
    logic por_fast;
    logic security;
    logic decompress;
    logic [1:0] width;
  } ctrl_t;

  localparam int CTRL_W = $bits(ctrl_t);
  localparam ctrl_t CTRL_RST = '0;

  typedef enum logic [2:0] {
    ST_POR,
    ST_RESET,
    ST_WAIT,
    ST_LOAD,
    ST_DONE,
    ST_INIT,
    ST_USER
  } cfg_state_t;

  // Pins after synchronisation
  typedef struct packed {
    logic cfg_clk;
    logic req_n;
    logic status_n;
    logic ustart_clk;
    logic [31:0] data;
  } pins_t;

endpackage : passive_config_pkg

// ==== passive_config_port.sv ====
// Passive configuration port: pin handshakes, bitstream loading, start-up, AHB-Lite registers
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module passive_config_port
  import passive_config_pkg::*;
#(
  parameter int POR_FAST_CYCLES = POR_FAST_CYC,
  parameter int POR_STD_CYCLES = POR_STD_CYC,
  parameter int USER_INIT_CYCLES = USER_INIT_CLKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration pins
  input wire logic config_clock,
  input wire logic config_req_n,
  input wire logic [31:0] config_data,
  input wire logic user_startup_clock,
  input wire logic status_n_i,
  output logic status_n_o,
  output logic status_n_oe,
  output logic done_o,
  output logic done_oe,
  output logic init_done_o,
  output logic init_done_oe,
  output logic user_mode
);

  // Whole block state in one record, so the next state is built in one process
  typedef struct packed {
    cfg_state_t st;
    logic [31:0] cnt;
    logic ugate;
    logic [2:0] phase;
    logic [31:0] bits;
    logic [31:0] words;
    logic [31:0] last;
    logic [1:0] falls;
    logic clk_q;
    logic uclk_q;
    logic status_oe;
    logic done_oe;
    logic init_oe;
    logic user;
    ctrl_t ctrl;
    logic [31:0] length;
    logic a_sel;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic ready;
  } port_state_t;

  port_state_t s_r;
  port_state_t s_nxt;
  pins_t pin_raw;
  pins_t pin;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  assign pin_raw.cfg_clk = config_clock;
  assign pin_raw.req_n = config_req_n;
  // Status is sensed back from the wire, so an external hold is seen
  assign pin_raw.status_n = status_n_i;
  assign pin_raw.ustart_clk = user_startup_clock;
  assign pin_raw.data = config_data;

  // Data is synchronised with the clock so both arrive with the same delay
  pin_sync #(.W($bits(pins_t))) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(pin_raw),
    .q(pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] ratio_m1(input ctrl_t c);
    logic [2:0] r;
    // Only 32-bit loading has a ratio above one
    r = RM1_PLAIN;
    if (c.width == W_X32) begin
      if (c.decompress) begin
        r = RM1_DECOMP;
      end else if (c.security) begin
        r = RM1_SECURE;
      end
    end
    return r;
  endfunction : ratio_m1

  function automatic logic [31:0] word_bits(input logic [1:0] w);
    logic [31:0] b;
    b = 32'h0000_0001;
    if (w == W_X8) begin
      b = 32'h0000_0008;
    end else if (w == W_X16) begin
      b = 32'h0000_0010;
    end else if (w == W_X32) begin
      b = 32'h0000_0020;
    end
    return b;
  endfunction : word_bits

  function automatic logic [31:0] word_value(input logic [1:0] w, input logic [31:0] d,
                                             input logic [31:0] prev);
    logic [31:0] v;
    // Serial shifts in at bit 0, so the first bit ends up most significant
    v = {prev[30:0], d[0]};
    if (w == W_X8) begin
      v = {24'h00_0000, d[7:0]};
    end else if (w == W_X16) begin
      v = {16'h0000, d[15:0]};
    end else if (w == W_X32) begin
      v = d;
    end
    return v;
  endfunction : word_value

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic rise;
    logic fall;
    logic urise;
    logic [31:0] nb;
    logic [31:0] por_cyc;
    logic take;
    rise = pin.cfg_clk & ~s_r.clk_q;
    fall = ~pin.cfg_clk & s_r.clk_q;
    urise = pin.ustart_clk & ~s_r.uclk_q;
    nb = s_r.bits;
    por_cyc = s_r.ctrl.por_fast ? 32'(POR_FAST_CYCLES) : 32'(POR_STD_CYCLES);
    take = hsel && hready && htrans == HTRANS_NONSEQ;
    s_nxt = s_r;
    s_nxt.clk_q = pin.cfg_clk;
    s_nxt.uclk_q = pin.ustart_clk;

    // Bus data phase: writes land here
    if (s_r.a_sel && s_r.a_wr) begin
      if (s_r.a_addr == A_CTRL) begin
        s_nxt.ctrl = ctrl_t'(hwdata[CTRL_W-1:0]);
      end else if (s_r.a_addr == A_LENGTH) begin
        s_nxt.length = hwdata;
      end
    end

    case (s_r.st)
      ST_POR: begin
        // Request is not honoured until the power-on delay has run out
        s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        if (s_r.cnt >= por_cyc) begin
          s_nxt.st = ST_WAIT;
          s_nxt.status_oe = 1'b0;
          s_nxt.cnt = '0;
        end
      end
      ST_RESET: begin
        // Count saturates so a long request hold cannot wrap it
        if (s_r.cnt < 32'(STATUS_MIN_CYC)) begin
          s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        end
        // Low pulse ends once the request is back high and the least width has passed
        if (pin.req_n && s_r.cnt >= 32'(STATUS_MIN_CYC)) begin
          s_nxt.st = ST_WAIT;
          s_nxt.status_oe = 1'b0;
        end
      end
      ST_WAIT, ST_LOAD: begin
        // An external hold on status keeps the first word from being taken
        if (rise && (s_r.st == ST_LOAD || pin.status_n)) begin
          s_nxt.st = ST_LOAD;
          if (s_r.phase == 3'h0) begin
            nb = s_r.bits + word_bits(s_r.ctrl.width);
            s_nxt.bits = nb;
            s_nxt.words = s_r.words + 32'h0000_0001;
            s_nxt.last = word_value(s_r.ctrl.width, pin.data, s_r.last);
            if (s_r.ctrl.init_done_en) begin
              s_nxt.init_oe = 1'b1;
            end
          end
          // Remaining clocks of the word are processing time
          if (s_r.phase >= ratio_m1(s_r.ctrl)) begin
            s_nxt.phase = 3'h0;
            if (nb >= s_r.length) begin
              s_nxt.st = ST_DONE;
              s_nxt.done_oe = 1'b0;
              s_nxt.falls = 2'h0;
            end
          end else begin
            s_nxt.phase = s_r.phase + 3'h1;
          end
        end
      end
      ST_DONE: begin
        // Only falls count here; rises after done carry no data
        if (fall) begin
          s_nxt.falls = s_r.falls + 2'h1;
          if (s_r.falls == 2'h1) begin
            s_nxt.st = ST_INIT;
            s_nxt.cnt = '0;
            s_nxt.ugate = 1'b0;
          end
        end
      end
      ST_INIT: begin
        // Internal path counts system clocks; user clock path counts its rises
        if (!s_r.ctrl.user_clk_en) begin
          s_nxt.cnt = s_r.cnt + 32'h0000_0001;
          if (s_r.cnt >= 32'(INT_INIT_CYC)) begin
            s_nxt.st = ST_USER;
          end
        end else if (!s_r.ugate) begin
          s_nxt.cnt = s_r.cnt + 32'h0000_0001;
          if (s_r.cnt >= 32'(CD2CU_CYC)) begin
            s_nxt.ugate = 1'b1;
            s_nxt.cnt = '0;
          end
        end else if (urise) begin
          s_nxt.cnt = s_r.cnt + 32'h0000_0001;
          if (s_r.cnt >= 32'(USER_INIT_CYCLES - 1)) begin
            s_nxt.st = ST_USER;
          end
        end
        if (s_nxt.st == ST_USER) begin
          s_nxt.user = 1'b1;
          s_nxt.init_oe = 1'b0;
        end
      end
      ST_USER: begin
        // Stays here until the request line drops
        s_nxt.user = 1'b1;
      end
      default: begin
        s_nxt.st = ST_POR;
      end
    endcase

    // Request low overrides every state once power-on delay has passed
    if (!pin.req_n && s_r.st != ST_POR) begin
      s_nxt.st = ST_RESET;
      s_nxt.cnt = (s_r.st == ST_RESET) ? s_nxt.cnt : 32'h0000_0000;
      s_nxt.status_oe = 1'b1;
      s_nxt.done_oe = 1'b1;
      s_nxt.init_oe = 1'b0;
      s_nxt.user = 1'b0;
      s_nxt.bits = '0;
      s_nxt.words = '0;
      s_nxt.phase = 3'h0;
      s_nxt.ugate = 1'b0;
    end

    // Bus address phase: reads see any write of this cycle
    // Transfer size is not checked: every register is one aligned word
    s_nxt.a_sel = take;
    s_nxt.a_wr = hwrite;
    s_nxt.a_addr = haddr[7:0];
    s_nxt.rdata = '0;
    if (take && !hwrite) begin
      if (haddr[7:0] == A_CTRL) begin
        s_nxt.rdata = 32'(s_nxt.ctrl);
      end else if (haddr[7:0] == A_LENGTH) begin
        s_nxt.rdata = s_nxt.length;
      end else if (haddr[7:0] == A_STATUS) begin
        s_nxt.rdata = {24'h00_0000, pin.status_n, s_r.user, ~s_r.done_oe, 2'h0, s_r.st};
      end else if (haddr[7:0] == A_WORDS) begin
        s_nxt.rdata = s_r.words;
      end else if (haddr[7:0] == A_LAST) begin
        s_nxt.rdata = s_r.last;
      end
    end
    // No wait states: every register answers in the first data phase
    s_nxt.ready = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  // Status and done are held low from the very first cycle of reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.st <= ST_POR;
      s_r.status_oe <= 1'b1;
      s_r.done_oe <= 1'b1;
      s_r.ctrl <= CTRL_RST;
      s_r.length <= LENGTH_RST;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register; pins are open-drain, low when enabled

  // Drive values are fixed low, so only the enables move on the open-drain pins
  assign hrdata = s_r.rdata;
  assign hreadyout = s_r.ready;
  assign hresp = s_r.a_sel & 1'b0;
  assign status_n_o = s_r.a_sel & 1'b0;
  assign status_n_oe = s_r.status_oe;
  assign done_o = s_r.a_sel & 1'b0;
  assign done_oe = s_r.done_oe;
  assign init_done_o = s_r.a_sel & 1'b0;
  assign init_done_oe = s_r.init_oe;
  assign user_mode = s_r.user;

endmodule : passive_config_port

// ==== passive_config_port_chk.sv ====
// Pin checker of the passive configuration port
`timescale 1ns/1ns
module passive_config_port_chk #(
  parameter int POR_FAST_CYCLES = 50
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic config_req_n,
  input wire logic status_n_oe,
  input wire logic done_oe,
  input wire logic init_done_oe,
  input wire logic user_mode
);
  localparam int PULSE_MIN = 2680;
  localparam int REL_MAX = 15060;
  int req_cnt_r;
  int hi_cnt_r;
  int por_cnt_r;
  logic seen_req_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Request and power-on counters saturate so long idle spans never wrap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_cnt_r <= 0;
      hi_cnt_r <= 0;
      por_cnt_r <= 0;
      seen_req_r <= 1'b0;
    end else begin
      req_cnt_r <= $fell(config_req_n) ? 0 : (req_cnt_r < 20000 ? req_cnt_r + 1 : req_cnt_r);
      hi_cnt_r <= (config_req_n && status_n_oe && seen_req_r) ? hi_cnt_r + 1 : 0;
      por_cnt_r <= por_cnt_r < 1000000 ? por_cnt_r + 1 : por_cnt_r;
      seen_req_r <= seen_req_r | $fell(config_req_n);
    end
  end
  ////////////////////////////////////////////////////////////
  req_pull_a:
    assert property ($fell(config_req_n) |-> ##[1:6] (status_n_oe && done_oe && !user_mode))
      else $error("status or done not pulled after request");
  por_hold_a:
    assert property ($fell(status_n_oe) && !seen_req_r |-> por_cnt_r >= POR_FAST_CYCLES)
      else $error("status released before power-on delay");
  pulse_len_a:
    assert property ($fell(status_n_oe) && seen_req_r |-> req_cnt_r >= PULSE_MIN
      && req_cnt_r <= REL_MAX) else $error("status pulse length out of range");
  release_a:
    assert property (hi_cnt_r <= REL_MAX) else $error("status not released in time");
  done_hold_a:
    assert property (status_n_oe && !user_mode |-> done_oe) else $error("done released early");
  user_lines_a:
    assert property (user_mode |-> !status_n_oe && !done_oe) else $error("lines low in user mode");
  init_pin_a:
    assert property ($rose(init_done_oe) |-> done_oe && !status_n_oe && !user_mode)
      else $error("init pin pulled outside loading");
  start_gap_a:
    assert property ($rose(user_mode) |-> $past(done_oe, 40) == 1'b0)
      else $error("user mode too soon after done");
endmodule : passive_config_port_chk

bind passive_config_port passive_config_port_chk #(.POR_FAST_CYCLES(POR_FAST_CYCLES)) chk_i (
  .clk(clk), .sys_rst(sys_rst), .config_req_n(config_req_n), .status_n_oe(status_n_oe),
  .done_oe(done_oe), .init_done_oe(init_done_oe), .user_mode(user_mode));

// ==== passive_config_port_tb.sv ====
// Self-checking testbench of the passive configuration port
`timescale 1ns/1ns
module passive_config_port_tb;
  import passive_config_pkg::*;
  logic clk, sys_rst, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, config_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic config_clock, config_req_n, user_startup_clock, status_wire;
  logic status_n_o, status_n_oe, done_o, done_oe, init_done_o, init_done_oe, user_mode;
  int bad_count, checked, n, t0;
  int now_c = 0;
  ctrl_t ctrl_tab [7] = '{7'h03, 7'h4B, 7'h07, 7'h2F, 7'h02, 7'h01, 7'h00};
  int words_tab [7] = '{2, 2, 2, 3, 2, 2, 8};
  int r_tab [7] = '{1, 4, 8, 8, 1, 1, 1};
  int bits_tab [7] = '{32, 32, 32, 32, 16, 8, 1};
  assign status_wire = status_n_oe ? status_n_o : 1'b1;
  passive_config_port #(.POR_FAST_CYCLES(50), .POR_STD_CYCLES(80), .USER_INIT_CYCLES(20)) uut (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .config_clock(config_clock),
    .config_req_n(config_req_n), .config_data(config_data),
    .user_startup_clock(user_startup_clock), .status_n_i(status_wire),
    .status_n_o(status_n_o), .status_n_oe(status_n_oe), .done_o(done_o), .done_oe(done_oe),
    .init_done_o(init_done_o), .init_done_oe(init_done_oe), .user_mode(user_mode));
  config_host host (.clk(clk), .status_wire(status_wire), .config_clock(config_clock),
    .config_req_n(config_req_n), .config_data(config_data),
    .user_startup_clock(user_startup_clock));
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word
  // Read data is taken at the edge that ends the data phase
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(a, 1'b1, d, x);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(a, 1'b0, 32'h0, x);
    cmp_word(what, exp, x);
    cmp_bit("okay response", 1'b0, hresp);
  endtask : rd_chk
  ////////////////////////////////////////////////////////////
  always @(posedge clk) now_c <= now_c + 1;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (70000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bad_count = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t0 = now_c;
    @(posedge clk);
    cmp_bit("status held", 1'b1, status_n_oe);
    cmp_bit("done held", 1'b1, done_oe);
    cmp_bit("done level", 1'b0, done_o);
    cmp_bit("init level", 1'b0, init_done_o);
    cmp_bit("init released", 1'b0, init_done_oe);
    rd_chk("ctrl reset", A_CTRL, 32'h0);
    rd_chk("length reset", A_LENGTH, LENGTH_RST);
    wr(A_WORDS, 32'h0000_0055);
    rd_chk("words read only", A_WORDS, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    wr(A_CTRL, 32'h0000_0010);
    while (status_n_oe !== 1'b0 && now_c - t0 < 500) @(posedge clk);
    cmp_bit("power-on span", 1'b1, now_c - t0 >= 50 && now_c - t0 <= 60);
    repeat (25) @(posedge clk);
    wr(A_CTRL, 32'(ctrl_tab[0]));
    wr(A_LENGTH, 32'h0000_0040);
    host.run(1, 1);
    repeat (10) @(posedge clk);
    cmp_bit("done on short load", 1'b1, done_oe);
    rd_chk("short load words", A_WORDS, 32'h0000_0001);
    for (int i = 0; i < 7; i++) begin
      wr(A_CTRL, 32'(ctrl_tab[i]));
      wr(A_LENGTH, 32'(words_tab[i] * bits_tab[i]));
      host.reconfig();
      cmp_bit("user dropped", 1'b0, user_mode);
      rd_chk("words cleared", A_WORDS, 32'h0);
      host.run(words_tab[i] * r_tab[i] - 1, r_tab[i]);
      repeat (10) @(posedge clk);
      cmp_bit("done before last", 1'b1, done_oe);
      cmp_bit("init pin", ctrl_tab[i].init_done_en, init_done_oe);
      host.run(1, r_tab[i]);
      repeat (3) @(posedge clk);
      cmp_bit("done released", 1'b0, done_oe);
      rd_chk("word count", A_WORDS, 32'(words_tab[i]));
      if (ctrl_tab[i].width == W_X32) begin
        rd_chk("last word", A_LAST, 32'hA5C3_0000 + 32'(words_tab[i] - 1));
      end
      t0 = now_c;
      cmp_bit("no early start", 1'b0, user_mode);
      host.run(2, 1);
      while (user_mode !== 1'b1 && now_c - t0 < 6000) @(posedge clk);
      n = now_c - t0;
      if (ctrl_tab[i].user_clk_en) begin
        cmp_bit("user clock start", 1'b1, n >= 60 && n <= 400);
      end else begin
        cmp_bit("oscillator start", 1'b1, n >= 1740 && n <= 4370);
      end
      rd_chk("user status", A_STATUS, 32'h0000_00E6);
    end
    end_sim();
  end
endmodule : passive_config_port_tb

// ==== pin_sync.sv ====
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : pin_sync
